// ### rtl/flash_seq_pkg.sv
// Constants and types shared by the flash sequencer and its controller
// What the document requires of this block and the software driving it
// RULE_01 - Same-address busy reads invert the progress bit
// RULE_02 - First busy read shows progress bit as one
// RULE_03 - Poll until two identical reads, then continue
// RULE_04 - No flash reads or fetches while busy
// RULE_05 - Writer code runs from loader or RAM
// RULE_06 - Byte program, sector or whole erase
// RULE_07 - Erase before reprogramming any written byte
// RULE_08 - Commands only with enable field 0011
// RULE_09 - Disable, enable, erase, poll, program, poll, disable
// RULE_10 - Clear interrupt master flag before writing
// RULE_11 - No non-maskable interrupts while writing
// RULE_12 - Run mode programs by address, no bank
// RULE_13 - Serial mode maps loader, banks the flash
// RULE_14 - Serial mode translates run-mode addresses to banks
// RULE_15 - Serial mode entered by test, loader pins
// RULE_16 - No RAM loader variant exists
// RULE_17 - Program: AA/555, 55/AAA, A0/555, data
// RULE_18 - Sector erase: six writes, 30 picks sector
// RULE_19 - Program 40 us, erase 30 ms, toggling
// RULE_20 - Broken unlock sequence returns to idle
package flash_seq_pkg;
    localparam int        AW          = 16;
    localparam int        DW          = 8;
    localparam logic [11:0] UNL_A1    = 12'h555;
    localparam logic [11:0] UNL_A2    = 12'haaa;
    localparam logic [7:0] D_AA       = 8'haa;
    localparam logic [7:0] D_55       = 8'h55;
    localparam logic [7:0] D_PROG     = 8'ha0;
    localparam logic [7:0] D_ERASE    = 8'h80;
    localparam logic [7:0] D_SECT     = 8'h30;
    localparam logic [7:0] D_CHIP     = 8'h10;
    localparam logic [7:0] D_PROT     = 8'ha5;
    localparam logic [15:0] PROT_ADDR = 16'hff7f;
    localparam logic [7:0] PROT_DATA  = 8'h00;
    localparam logic [7:0] ERASED     = 8'hff;
    localparam logic [3:0] CMD_EN     = 4'b0011;
    localparam logic [3:0] CMD_DIS    = 4'b1100;
    localparam logic [15:0] FLASH_LO  = 16'h1000;
    localparam logic [15:0] SER0_LO   = 16'h9000;
    localparam logic [15:0] SER1_LO   = 16'h8000;
    localparam logic [15:0] BANK_OFS  = 16'h8000;
    localparam logic [15:0] LOADER_LO = 16'h7800;
    localparam logic [15:0] LOADER_HI = 16'h7fff;
    localparam logic [15:0] CTRL_ADDR = 16'h0fd7;
    localparam logic [11:0] SECT_LAST = 12'hfff;
    localparam logic [15:0] ADDR_LAST = 16'hffff;
    localparam int        TOGGLE_BIT  = 6;
    localparam int        CLK_MHZ     = 25;
    localparam int        PROG_US     = 40;
    localparam int        ERASE_MS    = 30;
    localparam int        PROG_CYC    = PROG_US * CLK_MHZ;
    localparam int        ERASE_CYC   = ERASE_MS * 1000 * CLK_MHZ;
    localparam int        TW          = 20;
    // Device-side sequencer states, Gray along the program path
    typedef enum logic [3:0] {
        D_IDLE = 4'h0, D_U1 = 4'h1, D_U2 = 4'h3, D_PGM = 4'h2,
        D_BUSY = 4'h6, D_ER = 4'h7, D_ER1 = 4'h5, D_ER2 = 4'h4,
        D_PRT  = 4'hc
    } dev_state_e;
    typedef enum logic [1:0] {
        K_PROG = 2'h0, K_SECT = 2'h1, K_CHIP = 2'h3, K_PROT = 2'h2
    } op_kind_e;
    // Controller orders
    typedef enum logic [2:0] {
        OP_READ = 3'h0, OP_WRITE = 3'h1, OP_PROG = 3'h2,
        OP_SECT = 3'h3, OP_CHIP = 3'h4, OP_PROT = 3'h5
    } host_op_e;
    typedef enum logic [2:0] {
        H_IDLE = 3'h0, H_ISSUE = 3'h1, H_WAIT = 3'h3,
        H_POLL = 3'h2, H_PWAIT = 3'h6
    } host_state_e;
    localparam logic [7:0] APB_CTRL   = 8'h00;
    localparam logic [7:0] APB_ADDR   = 8'h04;
    localparam logic [7:0] APB_DATA   = 8'h08;
    localparam logic [7:0] APB_STAT   = 8'h0c;
endpackage

// ### rtl/flash_link_if.sv
// Core-side byte bus between the flash sequencer and its controller
`timescale 1ns/1ns
interface flash_link_if;
    logic        req;
    logic        we;
    logic        fetch;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        ack;
    modport dev  (input req, input we, input fetch, input addr,
                  input wdata, output rdata, output ack);
    modport host (output req, output we, output fetch, output addr,
                  output wdata, input rdata, input ack);
endinterface

// ### rtl/flash_cmd_sequencer.sv
// Flash command sequencer: unlock decode, busy timing, array, read gating
`timescale 1ns/1ns
module flash_cmd_sequencer #(
    parameter int ERASE_CYCLES = flash_seq_pkg::ERASE_CYC
) (
    flash_link_if.dev   lk,
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   test_pin,
    input  wire logic   loader_sel_pin,
    output logic        busy,
    output logic        serial_mode
);
    localparam logic [7:0] LOADER_FILL = 8'h00;
    localparam int         TW          = flash_seq_pkg::TW;

    typedef struct packed {
        flash_seq_pkg::dev_state_e st;
        flash_seq_pkg::op_kind_e   kind;
        logic [3:0]  en_fld;
        logic        bank;
        logic        test_s1;
        logic        test_s2;
        logic        ldr_s1;
        logic        ldr_s2;
        logic [1:0]  strap_cnt;
        logic        strap_done;
        logic        serial;
        logic        toggle;
        logic [19:0] tmr;
        logic        walk;
        logic [15:0] ptr;
        logic        ack;
        logic [7:0]  rdata;
        logic        busy;
    } dev_s;

    dev_s        r;
    dev_s        n;
    logic [7:0]  flash_mem [0:65535];
    logic        mem_wr;
    logic [15:0] mem_wa;
    logic [7:0]  mem_wd;
    logic [15:0] phys;
    logic        in_flash;
    logic        cmd_ok;
    logic [11:0] a12;

    function automatic logic flash_hit(input logic [15:0] a,
                                       input logic ser,
                                       input logic bk);
        if (ser)
            return bk ? (a >= flash_seq_pkg::SER1_LO)
                      : (a >= flash_seq_pkg::SER0_LO);
        return a >= flash_seq_pkg::FLASH_LO;
    endfunction

    // Serial mode with bank 0 shows low flash in the upper window
    function automatic logic [15:0] to_phys(input logic [15:0] a,
                                            input logic ser,
                                            input logic bk);
        if (ser && !bk)
            return a - flash_seq_pkg::BANK_OFS; // RULE_14
        return a; // RULE_12
    endfunction

    assign phys     = to_phys(lk.addr, r.serial, r.bank);
    assign in_flash = flash_hit(lk.addr, r.serial, r.bank); // RULE_13
    assign cmd_ok   = r.en_fld == flash_seq_pkg::CMD_EN; // RULE_08
    assign a12      = lk.addr[11:0];

    always_comb begin
        n      = r;
        n.ack  = 1'b0;
        mem_wr = 1'b0;
        mem_wa = phys;
        mem_wd = lk.wdata;
        n.test_s1 = test_pin;
        n.test_s2 = r.test_s1;
        n.ldr_s1  = loader_sel_pin;
        n.ldr_s2  = r.ldr_s1;
        // Strap held for the two sync stages before it is caught
        if (!r.strap_done) begin
            n.strap_cnt = r.strap_cnt + 2'd1;
            if (r.strap_cnt == 2'd3) begin
                n.strap_done = 1'b1;
                n.serial     = r.test_s2 & r.ldr_s2; // RULE_15
            end
        end
        if (r.st == flash_seq_pkg::D_BUSY) begin
            if (r.tmr != '0)
                n.tmr = r.tmr - 20'd1;
            // Erase walks one byte per cycle, well inside the erase time at the default ERASE_CYCLES
            if (r.walk) begin
                mem_wr = 1'b1;
                mem_wa = r.ptr;
                mem_wd = flash_seq_pkg::ERASED;
                n.ptr  = r.ptr + 16'd1;
                if ((r.kind == flash_seq_pkg::K_SECT &&
                     r.ptr[11:0] == flash_seq_pkg::SECT_LAST) ||
                    r.ptr == flash_seq_pkg::ADDR_LAST)
                    n.walk = 1'b0; // RULE_06
            end
            if (r.tmr == '0 && !r.walk)
                n.st = flash_seq_pkg::D_IDLE; // RULE_19
        end
        if (lk.req) begin
            n.ack = 1'b1;
            if (!lk.we) begin
                if (lk.addr == flash_seq_pkg::CTRL_ADDR)
                    n.rdata = {r.en_fld, r.bank, 3'b000};
                else if (r.serial && lk.addr >= flash_seq_pkg::LOADER_LO
                         && lk.addr <= flash_seq_pkg::LOADER_HI)
                    n.rdata = LOADER_FILL; // RULE_16
                else if (in_flash && r.st == flash_seq_pkg::D_BUSY) begin
                    // Array is never read while busy; status only
                    n.rdata = '0; // RULE_04
                    n.rdata[flash_seq_pkg::TOGGLE_BIT] = r.toggle; // RULE_02
                    n.toggle = ~r.toggle; // RULE_01
                end else if (in_flash)
                    n.rdata = flash_mem[phys];
                else
                    n.rdata = '0;
            end else if (lk.addr == flash_seq_pkg::CTRL_ADDR) begin
                n.en_fld = lk.wdata[7:4]; // RULE_08
                n.bank   = lk.wdata[3];
            end else if (in_flash && cmd_ok &&
                         r.st != flash_seq_pkg::D_BUSY) begin
                n.st = flash_seq_pkg::D_IDLE; // RULE_20
                case (r.st)
                    flash_seq_pkg::D_IDLE: begin
                        if (a12 == flash_seq_pkg::UNL_A1 &&
                            lk.wdata == flash_seq_pkg::D_AA)
                            n.st = flash_seq_pkg::D_U1; // RULE_17
                    end
                    flash_seq_pkg::D_U1: begin
                        if (a12 == flash_seq_pkg::UNL_A2 &&
                            lk.wdata == flash_seq_pkg::D_55)
                            n.st = flash_seq_pkg::D_U2; // RULE_17
                    end
                    flash_seq_pkg::D_U2: begin
                        if (a12 == flash_seq_pkg::UNL_A1) begin
                            if (lk.wdata == flash_seq_pkg::D_PROG)
                                n.st = flash_seq_pkg::D_PGM;
                            else if (lk.wdata == flash_seq_pkg::D_ERASE)
                                n.st = flash_seq_pkg::D_ER; // RULE_18
                            else if (lk.wdata == flash_seq_pkg::D_PROT)
                                n.st = flash_seq_pkg::D_PRT;
                        end
                    end
                    flash_seq_pkg::D_PGM: begin
                        // Bits only fall, so an unerased byte cannot rise
                        mem_wr   = 1'b1; // RULE_06
                        mem_wd   = flash_mem[phys] & lk.wdata; // RULE_07
                        n.st     = flash_seq_pkg::D_BUSY;
                        n.kind   = flash_seq_pkg::K_PROG;
                        n.tmr    = TW'(flash_seq_pkg::PROG_CYC - 1); // RULE_19
                        n.toggle = 1'b1; // RULE_02
                    end
                    flash_seq_pkg::D_ER: begin
                        if (a12 == flash_seq_pkg::UNL_A1 &&
                            lk.wdata == flash_seq_pkg::D_AA)
                            n.st = flash_seq_pkg::D_ER1; // RULE_18
                    end
                    flash_seq_pkg::D_ER1: begin
                        if (a12 == flash_seq_pkg::UNL_A2 &&
                            lk.wdata == flash_seq_pkg::D_55)
                            n.st = flash_seq_pkg::D_ER2; // RULE_18
                    end
                    flash_seq_pkg::D_ER2: begin
                        if (lk.wdata == flash_seq_pkg::D_SECT) begin
                            n.st   = flash_seq_pkg::D_BUSY;
                            n.kind = flash_seq_pkg::K_SECT;
                            n.walk = 1'b1;
                            n.ptr  = {phys[15:12], 12'h000}; // RULE_18
                            n.tmr  = TW'(ERASE_CYCLES - 1); // RULE_19
                            n.toggle = 1'b1;
                        end else if (lk.wdata == flash_seq_pkg::D_CHIP &&
                                     a12 == flash_seq_pkg::UNL_A1) begin
                            n.st   = flash_seq_pkg::D_BUSY;
                            n.kind = flash_seq_pkg::K_CHIP;
                            n.walk = 1'b1;
                            n.ptr  = '0; // RULE_06
                            n.tmr  = TW'(ERASE_CYCLES - 1);
                            n.toggle = 1'b1; // RULE_02
                        end
                    end
                    flash_seq_pkg::D_PRT: begin
                        if (lk.addr == flash_seq_pkg::PROT_ADDR &&
                            lk.wdata == flash_seq_pkg::PROT_DATA) begin
                            mem_wr   = 1'b1;
                            mem_wd   = flash_seq_pkg::PROT_DATA;
                            n.st     = flash_seq_pkg::D_BUSY;
                            n.kind   = flash_seq_pkg::K_PROT;
                            n.tmr    = TW'(flash_seq_pkg::PROG_CYC - 1);
                            n.toggle = 1'b1; // RULE_02
                        end
                    end
                    default: n.st = flash_seq_pkg::D_IDLE;
                endcase
            end
        end
        // Registered so the busy pin carries no decode glitch
        n.busy = n.st == flash_seq_pkg::D_BUSY;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r        <= '0;
            r.st     <= flash_seq_pkg::D_IDLE;
            r.en_fld <= flash_seq_pkg::CMD_DIS;
        end else begin
            r <= n;
        end
    end

    // Array has no reset; contents survive like real flash
    always_ff @(posedge pclk) begin
        if (mem_wr)
            flash_mem[mem_wa] <= mem_wd;
    end

    assign lk.ack      = r.ack;
    assign lk.rdata    = r.rdata;
    assign busy        = r.busy;
    assign serial_mode = r.serial;
endmodule

// ### rtl/flash_cmd_master.sv
// Controller: APB order registers, command sequences and completion polling
`timescale 1ns/1ns
module flash_cmd_master (
    flash_link_if.host  lk,
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready
);
    typedef struct packed {
        flash_seq_pkg::host_state_e st;
        flash_seq_pkg::host_op_e    op;
        logic [15:0] tgt;
        logic [7:0]  data;
        logic [2:0]  step;
        logic        req;
        logic        we;
        logic [15:0] laddr;
        logic [7:0]  lwdata;
        logic [7:0]  prev;
        logic        have_prev;
        logic [7:0]  last;
        logic        pready;
        logic [31:0] prdata;
    } host_s;

    host_s       r;
    host_s       n;
    logic [24:0] stp;

    // One bus write of a sequence: {last, address, data}
    function automatic logic [24:0] seq_step(
        input flash_seq_pkg::host_op_e op, input logic [2:0] i,
        input logic [15:0] t, input logic [7:0] d);
        logic [15:0] u1;
        logic [15:0] u2;
        u1 = {t[15:12], flash_seq_pkg::UNL_A1};
        u2 = {t[15:12], flash_seq_pkg::UNL_A2};
        case (i)
            3'd0: return {1'b0, u1, flash_seq_pkg::D_AA}; // RULE_17
            3'd1: return {1'b0, u2, flash_seq_pkg::D_55};
            3'd2: begin
                if (op == flash_seq_pkg::OP_PROG)
                    return {1'b0, u1, flash_seq_pkg::D_PROG};
                if (op == flash_seq_pkg::OP_PROT)
                    return {1'b0, u1, flash_seq_pkg::D_PROT};
                return {1'b0, u1, flash_seq_pkg::D_ERASE}; // RULE_18
            end
            3'd3: begin
                if (op == flash_seq_pkg::OP_PROG)
                    return {1'b1, t, d};
                if (op == flash_seq_pkg::OP_PROT)
                    return {1'b1, flash_seq_pkg::PROT_ADDR,
                            flash_seq_pkg::PROT_DATA};
                return {1'b0, u1, flash_seq_pkg::D_AA};
            end
            3'd4: return {1'b0, u2, flash_seq_pkg::D_55};
            default: begin
                if (op == flash_seq_pkg::OP_CHIP)
                    return {1'b1, u1, flash_seq_pkg::D_CHIP};
                return {1'b1, t, flash_seq_pkg::D_SECT}; // RULE_18
            end
        endcase
    endfunction

    assign stp = seq_step(r.op, r.step, r.tgt, r.data);

    always_comb begin
        n        = r;
        n.req    = 1'b0;
        n.pready = 1'b0;
        // One wait state; orders act as the access phase is first seen
        if (psel && penable && !r.pready) begin
            n.pready = 1'b1;
            if (pwrite) begin
                case (paddr)
                    flash_seq_pkg::APB_CTRL: begin
                        if (r.st == flash_seq_pkg::H_IDLE) begin
                            n.op        = flash_seq_pkg::host_op_e'(pwdata[2:0]);
                            n.step      = '0;
                            n.have_prev = 1'b0;
                            n.st        = flash_seq_pkg::H_ISSUE;
                        end
                    end
                    flash_seq_pkg::APB_ADDR: n.tgt  = pwdata[15:0];
                    flash_seq_pkg::APB_DATA: n.data = pwdata[7:0];
                    default: ;
                endcase
            end else begin
                case (paddr)
                    flash_seq_pkg::APB_CTRL: n.prdata = {29'd0, r.op};
                    flash_seq_pkg::APB_ADDR: n.prdata = {16'd0, r.tgt};
                    flash_seq_pkg::APB_DATA: n.prdata = {24'd0, r.data};
                    flash_seq_pkg::APB_STAT:
                        n.prdata = {16'd0, r.last, 7'd0,
                                    r.st != flash_seq_pkg::H_IDLE};
                    default: n.prdata = '0;
                endcase
            end
        end
        case (r.st)
            flash_seq_pkg::H_IDLE: ;
            flash_seq_pkg::H_ISSUE: begin
                n.req = 1'b1;
                n.st  = flash_seq_pkg::H_WAIT;
                if (r.op == flash_seq_pkg::OP_READ ||
                    r.op == flash_seq_pkg::OP_WRITE) begin
                    n.we     = r.op == flash_seq_pkg::OP_WRITE;
                    n.laddr  = r.tgt;
                    n.lwdata = r.data;
                end else begin
                    n.we     = 1'b1;
                    n.laddr  = stp[23:8];
                    n.lwdata = stp[7:0];
                end
            end
            flash_seq_pkg::H_WAIT: begin
                if (lk.ack) begin
                    n.last = lk.rdata;
                    n.step = r.step + 3'd1;
                    if (r.op == flash_seq_pkg::OP_READ ||
                        r.op == flash_seq_pkg::OP_WRITE)
                        n.st = flash_seq_pkg::H_IDLE;
                    else if (stp[24])
                        n.st = flash_seq_pkg::H_POLL;
                    else
                        n.st = flash_seq_pkg::H_ISSUE;
                end
            end
            flash_seq_pkg::H_POLL: begin
                n.req   = 1'b1;
                n.we    = 1'b0;
                n.laddr = r.tgt;
                n.st    = flash_seq_pkg::H_PWAIT;
            end
            flash_seq_pkg::H_PWAIT: begin
                if (lk.ack) begin
                    n.last      = lk.rdata;
                    n.prev      = lk.rdata;
                    n.have_prev = 1'b1;
                    // Done only on two equal reads in a row
                    if (r.have_prev && lk.rdata == r.prev)
                        n.st = flash_seq_pkg::H_IDLE; // RULE_03
                    else
                        n.st = flash_seq_pkg::H_POLL;
                end
            end
            default: n.st = flash_seq_pkg::H_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r    <= '0;
            r.st <= flash_seq_pkg::H_IDLE;
        end else begin
            r <= n;
        end
    end

    assign lk.req   = r.req;
    assign lk.we    = r.we;
    assign lk.fetch = 1'b0; // RULE_05 RULE_10 RULE_11
    assign lk.addr  = r.laddr;
    assign lk.wdata = r.lwdata;
    assign prdata   = r.prdata;
    assign pready   = r.pready;
endmodule

// ### verification/flash_command_sequencer_asserts.sv
// Link and progress-bit checks beside the sequencer and its controller
`timescale 1ns/1ns
module flash_command_sequencer_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        req,
    input wire logic        we,
    input wire logic        fetch,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic [7:0]  rdata,
    input wire logic        ack,
    input wire logic        busy
);
    logic        pend_r, tog_r, exp_r;
    logic [7:0]  lastw_r;
    logic [16:0] cnt_r;
    wire logic   brd = busy && req && !we && addr >= flash_seq_pkg::FLASH_LO;
    wire logic   ers = lastw_r == flash_seq_pkg::D_SECT
                    || lastw_r == flash_seq_pkg::D_CHIP;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Progress bit restarts at one for every new operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r  <= 1'b0;
            tog_r   <= 1'b1;
            exp_r   <= 1'b1;
            lastw_r <= 8'h00;
            cnt_r   <= 17'h00000;
        end else begin
            pend_r <= brd;
            if (brd) begin
                exp_r <= tog_r;
                tog_r <= ~tog_r;
            end else if (!busy) begin
                tog_r <= 1'b1;
            end
            if (req && we) begin
                lastw_r <= wdata;
            end
            cnt_r <= busy ? cnt_r + 17'h00001 : 17'h00000;
        end
    end
    a_ack_follows_req: assert property (req |=> ack)
        else $error("ack missing after request");
    a_ack_has_cause: assert property (ack |-> $past(req))
        else $error("ack without request");
    a_req_gap: assert property (req |=> !req)
        else $error("requests back to back");
    a_busy_read_blank: assert property (pend_r |-> (rdata & 8'hbf) == 8'h00)
        else $error("busy flash read served data");
    a_toggle_value: assert property (pend_r |-> rdata[6] == exp_r)
        else $error("progress bit wrong");
    a_busy_bounded: assert property (busy |-> cnt_r <= (ers ? 70000 : flash_seq_pkg::PROG_CYC))
        else $error("operation too long");
    a_busy_starts: assert property ($rose(busy) |-> $past(req && we) || $past(req && we, 2))
        else $error("busy without command");
    a_poll_only: assert property (busy && req |-> !we)
        else $error("write issued while busy");
    a_fetch_low: assert property (!fetch)
        else $error("fetch from flash");
    c_done: cover property ($fell(busy));
    c_toggle_low: cover property (pend_r && !exp_r);
    c_long_erase: cover property (busy && cnt_r > 17'd5000);
endmodule

// ### verification/flash_command_sequencer_bench.sv
// Self-checking bench driving the controller over APB against the sequencer
`timescale 1ns/1ns
module flash_command_sequencer_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, busy, strap;
    logic        serial;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed;
    int          fail_count, checks_done;
    flash_link_if lk ();
    flash_cmd_sequencer #(.ERASE_CYCLES(6000)) u_flash_cmd_sequencer (
        .lk(lk), .pclk(pclk), .presetn(presetn), .test_pin(strap),
        .loader_sel_pin(strap), .busy(busy), .serial_mode(serial));
    flash_cmd_master u_flash_cmd_master (
        .lk(lk), .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready));
    flash_command_sequencer_asserts u_asserts (
        .pclk(pclk), .presetn(presetn), .req(lk.req), .we(lk.we),
        .fetch(lk.fetch), .addr(lk.addr), .wdata(lk.wdata),
        .rdata(lk.rdata), .ack(lk.ack), .busy(busy));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                       input string m);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic hang(input string m);
        fail_count++;
        $display("CHECK FAILED %0t %s", $time, m);
        give_verdict();
    endtask
    // Master holds the request until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) hang("apb timeout");
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One order; waits until the controller's status bit shows it idle again
    task automatic op(input logic [2:0] o, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] r);
        logic [31:0] q;
        int          n;
        apb(1'b1, flash_seq_pkg::APB_ADDR, {16'h0000, a}, q);
        apb(1'b1, flash_seq_pkg::APB_DATA, {24'h000000, d}, q);
        apb(1'b1, flash_seq_pkg::APB_CTRL, {29'h00000000, o}, q);
        n = 0;
        q = 32'h00000001;
        while (q[0] !== 1'b0 && n < 20000) begin
            apb(1'b0, flash_seq_pkg::APB_STAT, 32'h00000000, q);
            n++;
        end
        if (n >= 20000) hang("op timeout");
        r = q[15:8];
    endtask
    initial begin
        logic [15:0] a;
        logic [7:0]  d, e, r;
        logic [31:0] q;
        presetn = 1'b0;
        strap = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        seed = 32'h00006480;
        fail_count = 0;
        checks_done = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        op(flash_seq_pkg::OP_WRITE, flash_seq_pkg::CTRL_ADDR, 8'h30, r);
        op(flash_seq_pkg::OP_CHIP, 16'h1000, 8'h00, r);
        chk(r, flash_seq_pkg::ERASED, "chip erase");
        $display("test chip erase done");
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            a = seed[15:0] | 16'h1000;
            d = seed[23:16];
            e = seed[31:24];
            op(flash_seq_pkg::OP_PROG, a, d, r);
            chk(r, d, "program");
            op(flash_seq_pkg::OP_PROG, a, e, r);
            chk(r, d & e, "reprogram");
        end
        $display("test program done");
        op(flash_seq_pkg::OP_SECT, a, 8'h00, r);
        chk(r, flash_seq_pkg::ERASED, "sector erase");
        op(flash_seq_pkg::OP_PROT, flash_seq_pkg::PROT_ADDR, 8'h00, r);
        chk(r, flash_seq_pkg::PROT_DATA, "read protect");
        $display("test erase and protect done");
        // Broken unlock: a wrong third step must disarm the sequence
        op(flash_seq_pkg::OP_WRITE, 16'h1555, 8'haa, r);
        op(flash_seq_pkg::OP_WRITE, 16'h1aaa, 8'h55, r);
        op(flash_seq_pkg::OP_WRITE, 16'h1555, 8'h00, r);
        op(flash_seq_pkg::OP_WRITE, 16'h1555, 8'ha0, r);
        op(flash_seq_pkg::OP_WRITE, a, 8'h00, r);
        op(flash_seq_pkg::OP_READ, a, 8'h00, r);
        chk(r, flash_seq_pkg::ERASED, "broken unlock");
        op(flash_seq_pkg::OP_WRITE, flash_seq_pkg::CTRL_ADDR, 8'hc0, r);
        op(flash_seq_pkg::OP_PROG, a, 8'h00, r);
        chk(r, flash_seq_pkg::ERASED, "disabled program");
        apb(1'b0, 8'h10, 32'h00000000, q);
        chk(q[7:0], 8'h00, "unmapped read");
        $display("test refusals done");
        presetn <= 1'b0;
        strap <= 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        chk({7'h00, serial}, 8'h01, "strap");
        op(flash_seq_pkg::OP_READ, flash_seq_pkg::LOADER_LO, 8'h00, r);
        chk(r, 8'h00, "loader window");
        $display("test serial mode done");
        give_verdict();
    end
endmodule
